// File: design/spdx_bmc_enc.sv
// Biphase-mark line encoder with preamble insertion
`timescale 1ns/1ps
module spdx_bmc_enc
  import spdx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Cell stream
  input wire logic run,
  input wire logic tick,
  input wire logic preamble,
  input wire logic pre_first,
  input wire logic pat_bit,
  input wire logic half,
  input wire logic data_bit,
  // Line
  output logic line_out
);

  logic level_r;
  logic level_nxt;
  logic ref_r;
  logic ref_nxt;

  always_comb begin
    level_nxt = level_r;
    ref_nxt = ref_r;
    if (!run) begin
      level_nxt = IDLE_LEVEL; // [RULE20]
      ref_nxt = IDLE_LEVEL;
    end else if (tick) begin
      if (preamble) begin
        // Pattern is relative to the level left by the previous subframe
        if (pre_first) begin
          ref_nxt = level_r;
        end
        level_nxt = pat_bit ^ (pre_first ? level_r : ref_r); // [RULE19]
      end else if (!half) begin
        level_nxt = ~level_r; // [RULE19]
      end else begin
        level_nxt = level_r ^ data_bit; // [RULE19]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_r <= IDLE_LEVEL;
      ref_r <= IDLE_LEVEL;
    end else begin
      level_r <= level_nxt;
      ref_r <= ref_nxt;
    end
  end

  assign line_out = level_r;

endmodule

// File: design/spdx_tx.sv
// Stereo digital-audio transmitter: source select, volume, framing, enable check
`timescale 1ns/1ps
module spdx_tx
  import spdx_pkg::*;
#(
  parameter int NUM_SRC = 8,
  parameter longint CORE_CLK_HZ = 125000000,
  parameter longint MIN_CELL_CYCLES = 4
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // Control
  input wire logic DIGITAL_AUDIO_TX_ENABLE,
  input wire logic [RATE_W-1:0] DIGITAL_AUDIO_TX_RATE_SELECT,
  input wire logic CORE_SYSTEM_CLOCK_ENABLE,
  input wire spdx_chan_ctrl_type CHANNEL_A_INPUT_SELECT,
  input wire spdx_chan_ctrl_type CHANNEL_B_INPUT_SELECT,
  input wire spdx_fields_type TX_FIELDS,
  // Sources from the routing matrix
  input wire logic [NUM_SRC-1:0][SAMPLE_W-1:0] MIXER_INPUT_SOURCE,
  // Status
  output logic TX_ACTIVE,
  output logic UNDERCLOCK_ERR,
  // Pin
  output logic SPDIF_OUT
);

  // ---------------------------------------------------------------
  // Rate and clock sufficiency
  // ---------------------------------------------------------------
  localparam logic [31:0] MAX_STEP = 32'((64'd1 << 32) / MIN_CELL_CYCLES);

  function automatic logic [31:0] rate_step(input logic [RATE_W-1:0] r);
    longint hz;
    hz = 0;
    case (r)
      RATE_32K: hz = 32000; // [RULE10]
      RATE_44K1: hz = 44100;
      RATE_48K: hz = 48000;
      RATE_88K2: hz = 88200;
      RATE_96K: hz = 96000;
      RATE_176K4: hz = 176400;
      RATE_192K: hz = 192000; // [RULE10]
      default: hz = 0;
    endcase
    rate_step = 32'(((hz * CELLS_PER_FRAME) << 32) / CORE_CLK_HZ);
  endfunction

  logic [31:0] step;
  logic clk_ok;

  assign step = rate_step(DIGITAL_AUDIO_TX_RATE_SELECT);
  // No core clock or too few cycles per line cell counts as underclocked
  assign clk_ok = CORE_SYSTEM_CLOCK_ENABLE && (step != 32'h0) && (step <= MAX_STEP); // [RULE16]

  // ---------------------------------------------------------------
  // Enable state
  // ---------------------------------------------------------------
  spdx_state_type state_r;
  spdx_state_type state_nxt;
  logic active;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TX_OFF: begin
        if (DIGITAL_AUDIO_TX_ENABLE) begin
          state_nxt = clk_ok ? TX_ON : TX_REFUSED; // [RULE13] [RULE16]
        end
      end
      TX_REFUSED: begin
        // Refusal holds until software drops the request and tries again
        if (!DIGITAL_AUDIO_TX_ENABLE) begin
          state_nxt = TX_OFF;
        end
      end
      TX_ON: begin
        if (!DIGITAL_AUDIO_TX_ENABLE) begin
          state_nxt = TX_OFF; // [RULE13]
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= TX_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Refusal only touches this path; nothing else is reset or stalled
  assign active = (state_r == TX_ON); // [RULE17]
  assign TX_ACTIVE = active; // [RULE18]
  assign UNDERCLOCK_ERR = (state_r == TX_REFUSED); // [RULE18]

  // ---------------------------------------------------------------
  // Source selection and volume
  // ---------------------------------------------------------------
  function automatic logic [SAMPLE_W-1:0] pick(input logic [SEL_W-1:0] sel,
      input logic [NUM_SRC-1:0][SAMPLE_W-1:0] src);
    pick = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (sel == SEL_W'(i + 1)) begin
        pick = src[i];
      end
    end
  endfunction

  function automatic logic [SAMPLE_W-1:0] scale(input logic [SAMPLE_W-1:0] smp,
      input logic [VOL_W-1:0] vol);
    logic signed [SAMPLE_W+VOL_W:0] p;
    logic [VOL_W-VOL_SHIFT+1:0] top;
    p = $signed(smp) * $signed({1'b0, vol});
    top = p[SAMPLE_W+VOL_W:SAMPLE_W+VOL_SHIFT-1];
    // Saturate instead of wrapping when gain pushes past full scale
    if ((top == '0) || (top == '1)) begin
      scale = p[SAMPLE_W+VOL_SHIFT-1:VOL_SHIFT];
    end else begin
      scale = p[SAMPLE_W+VOL_W] ? SAT_NEG : SAT_POS;
    end
  endfunction

  logic [SAMPLE_W-1:0] raw_a;
  logic [SAMPLE_W-1:0] raw_b;
  logic [SAMPLE_W-1:0] vol_a;
  logic [SAMPLE_W-1:0] vol_b;

  assign raw_a = pick(CHANNEL_A_INPUT_SELECT.sel, MIXER_INPUT_SOURCE); // [RULE3]
  assign raw_b = pick(CHANNEL_B_INPUT_SELECT.sel, MIXER_INPUT_SOURCE); // [RULE3]
  assign vol_a = scale(raw_a, CHANNEL_A_INPUT_SELECT.vol); // [RULE4]
  assign vol_b = scale(raw_b, CHANNEL_B_INPUT_SELECT.vol); // [RULE4]

  // ---------------------------------------------------------------
  // Cell timing and frame counters
  // ---------------------------------------------------------------
  logic [31:0] acc_r;
  logic [31:0] acc_nxt;
  logic tick;
  logic half_r;
  logic half_nxt;
  logic [4:0] slot_r;
  logic [4:0] slot_nxt;
  logic sub_r;
  logic sub_nxt;
  logic [7:0] frame_r;
  logic [7:0] frame_nxt;
  logic par_r;
  logic par_nxt;
  logic [SAMPLE_W-1:0] smp_a_r;
  logic [SAMPLE_W-1:0] smp_a_nxt;
  logic [SAMPLE_W-1:0] smp_b_r;
  logic [SAMPLE_W-1:0] smp_b_nxt;
  logic [SAMPLE_W-1:0] cur_smp;
  logic data_bit;
  logic preamble;
  logic [7:0] pattern;
  logic [2:0] pre_idx;

  assign tick = active && ({1'b0, acc_r} + {1'b0, step} > 33'h0FFFFFFFF);
  assign cur_smp = sub_r ? smp_b_r : smp_a_r;
  assign preamble = (slot_r < SLOT_AUDIO_FIRST);
  assign pre_idx = {slot_r[1:0], half_r};
  assign pattern = sub_r ? PRE_CHAN_B : ((frame_r == '0) ? PRE_BLOCK : PRE_CHAN_A); // [RULE19]

  always_comb begin
    data_bit = 1'b0;
    if ((slot_r >= SLOT_AUDIO_FIRST) && (slot_r <= SLOT_AUDIO_LAST)) begin
      data_bit = cur_smp[5'(slot_r - SLOT_AUDIO_FIRST)]; // [RULE14]
    end else if (slot_r == SLOT_VALID) begin
      data_bit = sub_r ? TX_FIELDS.validity_b : TX_FIELDS.validity_a; // [RULE2] [RULE15]
    end else if (slot_r == SLOT_USER) begin
      data_bit = 1'b0;
    end else if (slot_r == SLOT_CSTAT) begin
      // Bits past the held field send zero
      data_bit = (32'(frame_r) < CS_W) ? TX_FIELDS.cstat[frame_r[5:0]] : 1'b0; // [RULE2] [RULE19]
    end else if (slot_r == SLOT_PARITY) begin
      data_bit = par_r; // [RULE19]
    end
  end

  always_comb begin
    acc_nxt = acc_r;
    half_nxt = half_r;
    slot_nxt = slot_r;
    sub_nxt = sub_r;
    frame_nxt = frame_r;
    par_nxt = par_r;
    smp_a_nxt = smp_a_r;
    smp_b_nxt = smp_b_r;
    if (!active) begin
      acc_nxt = '0; // [RULE20]
      half_nxt = 1'b0;
      slot_nxt = '0;
      sub_nxt = 1'b0;
      frame_nxt = '0;
      par_nxt = 1'b0;
    end else begin
      acc_nxt = acc_r + step;
      if (tick) begin
        half_nxt = ~half_r;
        if (!half_r && (slot_r == '0) && !sub_r) begin
          smp_a_nxt = vol_a;
          smp_b_nxt = vol_b;
        end
        if (!half_r && (slot_r >= SLOT_AUDIO_FIRST) && (slot_r < SLOT_PARITY)) begin
          par_nxt = (slot_r == SLOT_AUDIO_FIRST) ? data_bit : (par_r ^ data_bit);
        end
        if (half_r) begin
          slot_nxt = slot_r + 5'h01;
          if (slot_r == SLOT_PARITY) begin
            sub_nxt = ~sub_r; // [RULE19]
            if (sub_r) begin
              frame_nxt = (frame_r == FRAME_LAST) ? '0 : (frame_r + 8'h01); // [RULE19]
            end
          end
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acc_r <= '0;
      half_r <= 1'b0;
      slot_r <= '0;
      sub_r <= 1'b0;
      frame_r <= '0;
      par_r <= 1'b0;
      smp_a_r <= '0;
      smp_b_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      half_r <= half_nxt;
      slot_r <= slot_nxt;
      sub_r <= sub_nxt;
      frame_r <= frame_nxt;
      par_r <= par_nxt;
      smp_a_r <= smp_a_nxt;
      smp_b_r <= smp_b_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Line encoder; output goes to the pin only, never back inward
  // ---------------------------------------------------------------
  spdx_bmc_enc u_enc (
    .clk(CLK),
    .reset_n(RESET_N),
    .run(active),
    .tick(tick),
    .preamble(preamble),
    .pre_first((slot_r == '0) && !half_r),
    .pat_bit(pattern[3'h7 - pre_idx]),
    .half(half_r),
    .data_bit(data_bit),
    .line_out(SPDIF_OUT) // [RULE1] [RULE5]
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  enable_accept_a: assert property ( // [RULE13]
    (state_r == TX_OFF) && DIGITAL_AUDIO_TX_ENABLE && clk_ok |=> TX_ACTIVE && !UNDERCLOCK_ERR)
    else $error("valid enable did not start transmitter");
  enable_refuse_a: assert property ( // [RULE16]
    (state_r == TX_OFF) && DIGITAL_AUDIO_TX_ENABLE && !clk_ok
      |=> !TX_ACTIVE && UNDERCLOCK_ERR)
    else $error("underclocked enable was not refused");
  refuse_holds_a: assert property ( // [RULE18]
    UNDERCLOCK_ERR && DIGITAL_AUDIO_TX_ENABLE |=> !TX_ACTIVE && UNDERCLOCK_ERR)
    else $error("refused transmitter came up without a new request");
  idle_level_a: assert property ( // [RULE20]
    !active |=> (SPDIF_OUT == IDLE_LEVEL) && (frame_r == '0) && (slot_r == '0) && !sub_r)
    else $error("disabled transmitter not idle at block start");
  cell_edge_a: assert property ( // [RULE19]
    tick && !half_r && !preamble |=> SPDIF_OUT != $past(SPDIF_OUT))
    else $error("missing transition at bit cell start");
  frame_wrap_a: assert property ( // [RULE19]
    tick && half_r && sub_r && (slot_r == SLOT_PARITY) && (frame_r == FRAME_LAST)
      |=> (frame_r == '0) && !sub_r && (slot_r == '0))
    else $error("block did not wrap after last frame");
  validity_bit_a: assert property ( // [RULE15]
    (slot_r == SLOT_VALID) && !sub_r |-> data_bit == TX_FIELDS.validity_a)
    else $error("channel A validity bit wrong");
  silent_sel_a: assert property ( // [RULE3]
    (CHANNEL_B_INPUT_SELECT.sel == SEL_SILENT) |-> vol_b == '0)
    else $error("unselected channel B not silent");
  sample_latch_a: assert property ( // [RULE4]
    tick && !half_r && (slot_r == '0) && !sub_r |=> smp_a_r == $past(vol_a))
    else $error("channel A sample not taken at frame start");

endmodule

// File: pkg/spdx_pkg.sv
// Constants, carriers and states for the stereo digital-audio transmitter
//
// Contract
// [RULE1] Produce a stereo consumer digital-audio stream on a general-purpose output pin.
// [RULE2] Software sets every validity flag and channel status bit sent; the code holds 64 status bits and sends zero in frames 64 to 191.
// [RULE3] First selector feeds channel A, second selector feeds channel B.
// [RULE4] Each channel scales its selected source by its own volume.
// [RULE5] The serial output never feeds back into any internal mixer.
// [RULE6] Source selection controls live at register addresses 800h to 809h.
// [RULE7] Software picks only same-clock, same-rate sources; others go through converters.
// [RULE8] Software keeps the transmitter disabled while the core clock is off.
// [RULE9] Software holds selectors at 00h until the core clock runs.
// [RULE10] Rate field selects sample rates from 32kHz up to 192kHz.
// [RULE11] Software clears all selectors to 00h before changing the rate.
// [RULE12] Software waits at least 125us after clearing selectors before rate writes.
// [RULE13] One enable bit turns the transmitter on; cleared means inactive.
// [RULE14] Samples of up to 24 bits per subframe are carried.
// [RULE15] Validity and channel status come from fields at 5C2h to 5C5h.
// [RULE16] Enable is refused and transmitter stays off when clocking is insufficient.
// [RULE17] A refused enable leaves other active signal paths untouched.
// [RULE18] After a refusal, status shows which paths really came up.
// [RULE19] Biphase-mark, preambles, two subframes, 192-frame blocks, one status bit per frame.
// [RULE20] Disabled output idles static; counters restart at block start on enable.
package spdx_pkg;

  // ---------------------------------------------------------------
  // Register map anchors
  // ---------------------------------------------------------------
  localparam logic [11:0] SEL_REG_FIRST = 12'h800; // [RULE6]
  localparam logic [11:0] SEL_REG_LAST = 12'h809; // [RULE6]
  localparam logic [11:0] FIELD_REG_FIRST = 12'h5C2;
  localparam logic [11:0] FIELD_REG_LAST = 12'h5C5;

  // ---------------------------------------------------------------
  // Widths and field values
  // ---------------------------------------------------------------
  localparam int SAMPLE_W = 24;
  localparam int SEL_W = 8;
  localparam int VOL_W = 8;
  localparam int RATE_W = 3;
  localparam int CS_W = 64;
  localparam int VOL_SHIFT = 7;
  localparam logic [SEL_W-1:0] SEL_SILENT = 8'h00;
  localparam logic [SAMPLE_W-1:0] SAT_POS = 24'h7FFFFF;
  localparam logic [SAMPLE_W-1:0] SAT_NEG = 24'h800000;

  // Sample rate codes
  localparam logic [RATE_W-1:0] RATE_32K = 3'h0;
  localparam logic [RATE_W-1:0] RATE_44K1 = 3'h1;
  localparam logic [RATE_W-1:0] RATE_48K = 3'h2;
  localparam logic [RATE_W-1:0] RATE_88K2 = 3'h3;
  localparam logic [RATE_W-1:0] RATE_96K = 3'h4;
  localparam logic [RATE_W-1:0] RATE_176K4 = 3'h5;
  localparam logic [RATE_W-1:0] RATE_192K = 3'h6;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam longint CELLS_PER_FRAME = 128;
  localparam logic [4:0] SLOT_AUDIO_FIRST = 5'h04;
  localparam logic [4:0] SLOT_AUDIO_LAST = 5'h1B;
  localparam logic [4:0] SLOT_VALID = 5'h1C;
  localparam logic [4:0] SLOT_USER = 5'h1D;
  localparam logic [4:0] SLOT_CSTAT = 5'h1E;
  localparam logic [4:0] SLOT_PARITY = 5'h1F;
  localparam logic [7:0] FRAME_LAST = 8'hBF;
  localparam logic [7:0] PRE_BLOCK = 8'hE8;
  localparam logic [7:0] PRE_CHAN_A = 8'hE2;
  localparam logic [7:0] PRE_CHAN_B = 8'hE4;
  localparam logic IDLE_LEVEL = 1'b0;

  // ---------------------------------------------------------------
  // Carriers and states
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [VOL_W-1:0] vol;
  } spdx_chan_ctrl_type;

  typedef struct packed {
    logic validity_a;
    logic validity_b;
    logic [CS_W-1:0] cstat;
  } spdx_fields_type;

  typedef enum logic [1:0] {TX_OFF, TX_REFUSED, TX_ON} spdx_state_type;

endpackage

// File: sim/spdx_rx_model.sv
// Behavioural receiver that decodes the biphase-mark line into subframes
`timescale 1ns/1ps
module spdx_rx_model #(
  parameter int CELL_CLKS = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Line
  input wire logic line_in,
  // Decoded subframe
  output logic sf_valid,
  output logic [7:0] sf_pre,
  output logic [27:0] sf_data,
  output logic sf_bmc_ok
);
  logic prev;
  logic [63:0] cells;
  int run;
  int idx;
  int n;

  // ---------------------------------------------------------------
  // Run-length slicer
  // ---------------------------------------------------------------
  // Cells jitter by one clock, so runs are rounded to whole cells
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev = 1'b0;
      run = 1000;
      idx = -1;
      sf_valid <= 1'b0;
    end else begin
      sf_valid <= 1'b0;
      if (line_in != prev) begin
        n = (run + CELL_CLKS / 2) / CELL_CLKS;
        if (n > 3 || n < 1) begin
          idx = -1;
        end else if (n == 3 && (idx < 0 || idx >= 8)) begin
          idx = 3;
          cells[63:61] = {3{prev}};
        end else if (idx >= 0 && idx < 64) begin
          for (int k = 0; k < n && idx < 64; k++) begin
            cells[63-idx] = prev;
            idx = idx + 1;
          end
          if (idx == 64) begin
            sf_pre <= cells[63] ? cells[63:56] : ~cells[63:56];
            sf_bmc_ok <= 1'b1;
            for (int s = 4; s < 32; s++) begin
              sf_data[s-4] <= cells[63-2*s] ^ cells[62-2*s];
              if (cells[63-2*s] == cells[64-2*s]) begin
                sf_bmc_ok <= 1'b0;
              end
            end
            sf_valid <= 1'b1;
          end
        end
        run = 1;
        prev = line_in;
      end else begin
        run = run + 1;
      end
    end
  end
endmodule

// File: sim/testbench.sv
// Testbench for the stereo digital-audio transmitter
`timescale 1ns/1ps
module testbench;
  import spdx_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic en = 1'b0;
  logic clk_on = 1'b0;
  logic [RATE_W-1:0] rate = 3'h0;
  spdx_chan_ctrl_type ch_a = '0;
  spdx_chan_ctrl_type ch_b = '0;
  spdx_fields_type flds = '0;
  logic [7:0][SAMPLE_W-1:0] src = '0;
  logic tx_act, uc_err, line, sf_v, bmc_ok;
  logic [7:0] pre;
  logic [27:0] dat;
  logic [7:0] pq[$];
  logic [28:0] dq[$];
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  spdx_tx DUT (.CLK(clk), .RESET_N(reset_n), .DIGITAL_AUDIO_TX_ENABLE(en),
    .DIGITAL_AUDIO_TX_RATE_SELECT(rate), .CORE_SYSTEM_CLOCK_ENABLE(clk_on),
    .CHANNEL_A_INPUT_SELECT(ch_a), .CHANNEL_B_INPUT_SELECT(ch_b), .TX_FIELDS(flds),
    .MIXER_INPUT_SOURCE(src), .TX_ACTIVE(tx_act), .UNDERCLOCK_ERR(uc_err), .SPDIF_OUT(line));

  spdx_rx_model #(.CELL_CLKS(5)) rx (.clk(clk), .reset_n(reset_n), .line_in(line),
    .sf_valid(sf_v), .sf_pre(pre), .sf_data(dat), .sf_bmc_ok(bmc_ok));

  // ---------------------------------------------------------------
  // Clock, watchdog and subframe capture
  // ---------------------------------------------------------------
  always #4 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      close_out();
    end
  end

  always @(posedge clk) begin
    if (sf_v) begin
      pq.push_back(pre);
      dq.push_back({bmc_ok, dat});
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task set_en(input logic v);
    en = v;
    step(2);
  endtask

  task wait_sf(input int k);
    int t;
    t = 0;
    while (pq.size() < k && t < 5000) begin
      step(1);
      t++;
    end
    if (pq.size() < k) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, pq.size(), k);
    end
  endtask

  task chk_sf(input logic [7:0] epre, input logic [23:0] es, input logic ev, input logic ecs);
    logic [7:0] p;
    logic [28:0] d;
    p = pq.pop_front();
    d = dq.pop_front();
    chk(p, epre);
    chk(d[23:0], es);
    chk(d[24], ev);
    chk(d[26], ecs);
    chk({d[28], d[25], ^d[27:0]}, 3'b100);
  endtask

  task close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    step(5);
    reset_n = 1'b1;
    step(1);
    chk({tx_act, uc_err, line}, 3'b000);
    $display("test reset done");
    // Clock absent first, then an unsupported rate code
    for (int i = 0; i < 2; i++) begin
      clk_on = (i == 1);
      rate = (i == 1) ? 3'h7 : 3'h6;
      set_en(1'b1);
      chk({tx_act, uc_err}, 2'b01);
      clk_on = 1'b1;
      rate = 3'h6;
      step(3);
      chk({tx_act, uc_err, line}, 3'b010);
      set_en(1'b0);
      chk({tx_act, uc_err}, 2'b00);
    end
    $display("test refusal done");
    // Selectors still 00h, so rate writes are allowed
    for (int r = 0; r < 7; r++) begin
      rate = r[2:0];
      set_en(1'b1);
      chk({tx_act, uc_err}, 2'b10);
      set_en(1'b0);
      chk(tx_act, 1'b0);
    end
    $display("test rates done");
    src[0] = 24'h5A5A5A;
    src[1] = 24'hFFFFFF;
    src[2] = 24'h123456;
    ch_a = '{sel: 8'h01, vol: 8'h80};
    ch_b = '{sel: 8'h03, vol: 8'h40};
    flds = '{validity_a: 1'b1, validity_b: 1'b0, cstat: 64'h5};
    pq.delete();
    dq.delete();
    set_en(1'b1);
    wait_sf(6);
    for (int f = 0; f < 3; f++) begin
      chk_sf((f == 0) ? 8'hE8 : 8'hE2, 24'h5A5A5A, 1'b1, ~f[0]);
      chk_sf(8'hE4, 24'h091A2B, 1'b0, ~f[0]);
    end
    $display("test stream done");
    set_en(1'b0);
    chk(tx_act, 1'b0);
    for (int k = 0; k < 50; k++) begin
      step(1);
      chk(line, IDLE_LEVEL);
    end
    // Negative sample at unity, then gain driving past full scale
    ch_a = '{sel: 8'h02, vol: 8'h80};
    ch_b = '{sel: 8'h01, vol: 8'hFF};
    pq.delete();
    dq.delete();
    set_en(1'b1);
    wait_sf(2);
    chk_sf(8'hE8, 24'hFFFFFF, 1'b1, 1'b1);
    chk_sf(8'hE4, 24'h7FFFFF, 1'b0, 1'b1);
    $display("test restart done");
    close_out();
  end
endmodule
